/* File: fsps_pkg.sv */
// Constants, types and register map for the flash self-program host
package fsps_pkg;

  // Clock and programming time
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned PROG_MAX_NS = 4_500_000;
  localparam int unsigned PROG_MAX_CYC = PROG_MAX_NS / CLK_PERIOD_NS;
  localparam logic [3:0] SETTLE_CYC = 4'h3;

  // AHB register offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // Command codes in the command register
  localparam logic [2:0] CMD_LOAD = 3'h1;
  localparam logic [2:0] CMD_ERASE = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_LOCK = 3'h4;
  localparam logic [2:0] CMD_REEN = 3'h5;

  // Status register bit positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_REFUSED = 1;
  localparam int unsigned ST_LOST = 2;
  localparam int unsigned ST_TIMEOUT = 3;
  localparam int unsigned ST_ERASED = 4;
  localparam int unsigned ST_EE = 5;
  localparam int unsigned ST_DEV_LSB = 8;

  // Device control register bits and patterns
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_BUSY_BIT = 6;
  localparam logic [7:0] CTRL_LOAD = 8'h01;
  localparam logic [7:0] CTRL_ERASE = 8'h03;
  localparam logic [7:0] CTRL_WRITE = 8'h05;
  localparam logic [7:0] CTRL_LOCK = 8'h09;
  localparam logic [7:0] CTRL_REEN = 8'h11;

  // Address pointer layout
  localparam int unsigned WORD_LSB = 1;
  localparam int unsigned WORD_BITS = 6;
  localparam int unsigned PAGE_LSB = 7;
  localparam int unsigned PAGE_BITS = 9;
  localparam int unsigned WORDS_PER_PAGE = 64;
  localparam logic [15:0] LOCK_ADDR = 16'h0001;
  localparam logic [7:0] LOCK_KEEP = 8'hC0;

  // Pins driven toward the device
  typedef struct packed {
    logic ctrl_wr;
    logic [7:0] ctrl;
    logic store;
    logic [15:0] addr;
    logic [7:0] dlo;
    logic [7:0] dhi;
  } fsps_pins_t;

  typedef enum logic [2:0] {
    S_IDLE, S_EE_WAIT, S_CTRL, S_SETTLE, S_POLL
  } fsps_state_t;

endpackage

/* File: fsps_host.sv */
// Host sequencer driving a flash self-program port, AHB-Lite command slave
//
// Register access over AHB-Lite and the address map were decided locally.
module fsps_host
  import fsps_pkg::*;
#(
  parameter int unsigned PROG_TIMEOUT_CYC = PROG_MAX_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic DEV_CTRL_WR_O,
  output logic [7:0] DEV_CTRL_O,
  output logic DEV_STORE_O,
  output logic [15:0] DEV_ADDR_O,
  output logic [7:0] DEV_DATA_LOW_O,
  output logic [7:0] DEV_DATA_HIGH_O,
  input wire logic [7:0] DEV_STATUS_I,
  input wire logic DEV_EE_BUSY_I
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] a);
    word_of = a[WORD_LSB +: WORD_BITS];
  endfunction

  function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] a);
    page_of = a[PAGE_LSB +: PAGE_BITS];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for device inputs

  logic [7:0] st_s1_q, st_s2_q;
  logic ee_s1_q, ee_s2_q;

  // Two stages before any logic looks
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      st_s1_q <= 8'h00;
      st_s2_q <= 8'h00;
      ee_s1_q <= 1'b0;
      ee_s2_q <= 1'b0;
    end else begin
      st_s1_q <= DEV_STATUS_I;
      st_s2_q <= st_s1_q;
      ee_s1_q <= DEV_EE_BUSY_I;
      ee_s2_q <= ee_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  fsps_state_t state_q, state_d;
  fsps_pins_t pins_q, pins_d;
  logic [2:0] op_q, op_d;
  logic reen_q, reen_d;
  logic [19:0] cnt_q, cnt_d;
  logic [WORDS_PER_PAGE-1:0] loaded_q, loaded_d;
  logic erased_q, erased_d;
  logic [PAGE_BITS-1:0] erased_pg_q, erased_pg_d;
  logic [15:0] addr_reg_q, addr_reg_d;
  logic [15:0] data_reg_q, data_reg_d;
  logic refused_q, refused_d;
  logic lost_q, lost_d;
  logic tmo_q, tmo_d;
  logic ph_wr_q, ph_wr_d;
  logic [7:0] ph_addr_q, ph_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic ap, cmd_go, bad;
  logic [2:0] cmd_code;
  logic [31:0] status;
  logic [7:0] pat;

  // Status word seen by software
  always_comb begin
    status = 32'h0000_0000;
    status[ST_BUSY] = (state_q != S_IDLE);
    status[ST_REFUSED] = refused_q;
    status[ST_LOST] = lost_q;
    status[ST_TIMEOUT] = tmo_q;
    status[ST_ERASED] = erased_q;
    status[ST_EE] = ee_s2_q;
    status[ST_DEV_LSB +: 8] = st_s2_q;
  end

  // Next-state logic for bus, registers and sequencer
  always_comb begin
    state_d = state_q;
    pins_d = pins_q;
    pins_d.ctrl_wr = 1'b0;
    pins_d.store = 1'b0;
    op_d = op_q;
    reen_d = reen_q;
    cnt_d = cnt_q;
    loaded_d = loaded_q;
    erased_d = erased_q;
    erased_pg_d = erased_pg_q;
    addr_reg_d = addr_reg_q;
    data_reg_d = data_reg_q;
    refused_d = refused_q;
    lost_d = lost_q;
    tmo_d = tmo_q;
    rdata_d = rdata_q;
    cmd_go = 1'b0;
    cmd_code = 3'h0;
    bad = 1'b0;
    pat = CTRL_LOAD;
    // Address phase capture
    ap = HSEL_I && HTRANS_I[1] && HREADY_I;
    ph_wr_d = ap && HWRITE_I;
    ph_addr_d = ap ? HADDR_I[7:0] : ph_addr_q;
    if (ap && !HWRITE_I) begin
      unique case (HADDR_I[7:0])
        OFS_ADDR: rdata_d = {16'h0000, addr_reg_q};
        OFS_DATA: rdata_d = {16'h0000, data_reg_q};
        OFS_STATUS: rdata_d = status;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    // Data phase writes; flag clears come before sets
    if (ph_wr_q) begin
      unique case (ph_addr_q)
        OFS_CMD: begin
          cmd_go = 1'b1;
          cmd_code = HWDATA_I[2:0];
        end
        OFS_ADDR: addr_reg_d = HWDATA_I[15:0];
        OFS_DATA: data_reg_d = HWDATA_I[15:0];
        OFS_STATUS: begin
          if (HWDATA_I[ST_REFUSED]) refused_d = 1'b0;
          if (HWDATA_I[ST_LOST]) lost_d = 1'b0;
          if (HWDATA_I[ST_TIMEOUT]) tmo_d = 1'b0;
        end
        default: ;
      endcase
    end
    // Control pattern for the pending operation
    if (reen_q) pat = CTRL_REEN;
    else if (op_q == CMD_ERASE) pat = CTRL_ERASE;
    else if (op_q == CMD_WRITE) pat = CTRL_WRITE;
    else if (op_q == CMD_LOCK) pat = CTRL_LOCK;
    else if (op_q == CMD_REEN) pat = CTRL_REEN;
    unique case (state_q)
      S_IDLE: begin
        if (cmd_go) begin
          if (cmd_code == CMD_WRITE) begin
            bad = !erased_q || (erased_pg_q != page_of(addr_reg_q));
          end
          // no second load of a word
          if (cmd_code == CMD_LOAD) begin
            bad = loaded_q[word_of(addr_reg_q)];
          end
          if (cmd_code == 3'h0 || cmd_code > CMD_REEN) bad = 1'b1;
          if (bad) begin
            refused_d = 1'b1;
          end else begin
            op_d = cmd_code;
            reen_d = 1'b0;
            state_d = S_EE_WAIT;
          end
        end
      end
      S_EE_WAIT: begin
        // wait EEPROM idle and prior op done
        if (!ee_s2_q && !st_s2_q[CTRL_EN_BIT]) begin
          pins_d.ctrl_wr = 1'b1;
          pins_d.ctrl = pat;
          pins_d.addr = addr_reg_q;
          pins_d.dlo = data_reg_q[7:0];
          pins_d.dhi = data_reg_q[15:8];
          if (!reen_q && (op_q == CMD_ERASE || op_q == CMD_WRITE)) begin
            pins_d.addr = {page_of(addr_reg_q), 7'h00};
          end
          if (!reen_q && op_q == CMD_LOCK) begin
            pins_d.addr = LOCK_ADDR;
            pins_d.dlo = data_reg_q[7:0] | LOCK_KEEP;
          end
          state_d = S_CTRL;
        end
      end
      S_CTRL: begin
        pins_d.store = 1'b1;
        cnt_d = 20'h0_0000;
        state_d = S_SETTLE;
      end
      S_SETTLE: begin
        cnt_d = cnt_q + 20'h0_0001;
        if (cnt_q[3:0] == SETTLE_CYC) begin
          cnt_d = 20'h0_0000;
          state_d = S_POLL;
        end
      end
      S_POLL: begin
        cnt_d = cnt_q + 20'h0_0001;
        // completion seen as enable bit clear
        if (!st_s2_q[CTRL_EN_BIT]) begin
          state_d = S_IDLE;
          if (reen_q || op_q == CMD_REEN) begin
            loaded_d = '0;
            if (st_s2_q[CTRL_BUSY_BIT]) begin
              reen_d = 1'b1;
              state_d = S_EE_WAIT;
            end
          end else begin
            unique case (op_q)
              CMD_LOAD: loaded_d[word_of(pins_q.addr)] = 1'b1;
              CMD_ERASE: begin
                erased_d = 1'b1;
                erased_pg_d = page_of(pins_q.addr);
              end
              CMD_WRITE: begin
                loaded_d = '0;
                erased_d = 1'b0;
              end
              default: ;
            endcase
            // re-enable region after erase or write
            if (op_q == CMD_ERASE || op_q == CMD_WRITE) begin
              reen_d = 1'b1;
              state_d = S_EE_WAIT;
            end
          end
        // give up past the longest programming time
        end else if (cnt_q == 20'(PROG_TIMEOUT_CYC - 1)) begin
          tmo_d = 1'b1;
          state_d = S_IDLE;
        end
      end
    endcase
    if (cmd_go && state_q != S_IDLE) refused_d = 1'b1;
    // EEPROM write discards the loaded words
    if (ee_s2_q && (|loaded_q)) begin
      loaded_d = '0;
      lost_d = 1'b1;
    end
  end

  // Register all state
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state_q <= S_IDLE;
      pins_q <= '0;
      op_q <= 3'h0;
      reen_q <= 1'b0;
      cnt_q <= 20'h0_0000;
      loaded_q <= '0;
      erased_q <= 1'b0;
      erased_pg_q <= '0;
      addr_reg_q <= 16'h0000;
      data_reg_q <= 16'h0000;
      refused_q <= 1'b0;
      lost_q <= 1'b0;
      tmo_q <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      pins_q <= pins_d;
      op_q <= op_d;
      reen_q <= reen_d;
      cnt_q <= cnt_d;
      loaded_q <= loaded_d;
      erased_q <= erased_d;
      erased_pg_q <= erased_pg_d;
      addr_reg_q <= addr_reg_d;
      data_reg_q <= data_reg_d;
      refused_q <= refused_d;
      lost_q <= lost_d;
      tmo_q <= tmo_d;
      ph_wr_q <= ph_wr_d;
      ph_addr_q <= ph_addr_d;
      rdata_q <= rdata_d;
    end
  end

  // Ports straight from flops; zero-wait OKAY slave
  assign HRDATA_O = rdata_q;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign DEV_CTRL_WR_O = pins_q.ctrl_wr;
  assign DEV_CTRL_O = pins_q.ctrl;
  assign DEV_STORE_O = pins_q.store;
  assign DEV_ADDR_O = pins_q.addr;
  assign DEV_DATA_LOW_O = pins_q.dlo;
  assign DEV_DATA_HIGH_O = pins_q.dhi;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence ctrl_then_store;
    pins_q.ctrl_wr ##1 pins_q.store && !pins_q.ctrl_wr;
  endsequence

  sequence write_store;
    pins_q.store && pins_q.ctrl == CTRL_WRITE;
  endsequence

  ctrl_store_pair_a: assert property (pins_q.ctrl_wr |-> ctrl_then_store)
    else $error("store did not follow control write");
  store_gap_a: assert property (pins_q.store |-> $past(pins_q.ctrl_wr, 1))
    else $error("store without control write just before");
  ee_idle_a: assert property (pins_q.ctrl_wr |-> !$past(ee_s2_q, 1))
    else $error("control write while EEPROM busy");
  write_erased_a: assert property (write_store |-> erased_q
    && erased_pg_q == page_of(pins_q.addr))
    else $error("page write without erase of same page");
  write_zero_a: assert property (write_store |-> pins_q.addr[PAGE_LSB-1:0] == 7'h00)
    else $error("page write with word bits set");
  lock_args_a: assert property (pins_q.store && pins_q.ctrl == CTRL_LOCK
    |-> pins_q.addr == LOCK_ADDR && pins_q.dlo[7:6] == 2'b11)
    else $error("lock arguments wrong");
  no_reload_a: assert property (pins_q.store && pins_q.ctrl == CTRL_LOAD
    |-> !loaded_q[word_of(pins_q.addr)])
    else $error("buffer word loaded twice");
  reen_follow_a: assert property (state_q == S_POLL && !reen_q
    && (op_q == CMD_ERASE || op_q == CMD_WRITE) && !st_s2_q[CTRL_EN_BIT]
    |=> reen_q && state_q == S_EE_WAIT)
    else $error("no re-enable after programming");
  reen_clear_a: assert property (state_q == S_POLL && reen_q
    && !st_s2_q[CTRL_EN_BIT] |=> loaded_q == '0)
    else $error("buffer map not cleared after re-enable");
  ee_discard_a: assert property (ee_s2_q && (|loaded_q)
    |=> loaded_q == '0 && lost_q)
    else $error("loaded words kept across EEPROM write");

endmodule

/* File: fsps_dev_model.sv */
// Behavioural model of the flash self-program port seen by the host
module fsps_dev_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_i,
  input wire logic store_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] dlo_i,
  input wire logic [7:0] dhi_i,
  input wire logic ee_busy_i,
  input wire logic [9:0] op_cyc_i,
  output logic [7:0] status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_q, rww_q;
  logic [7:0] ctl_q;
  logic [2:0] win_q;
  logic [9:0] cnt_q;
  logic [15:0] adr_q;
  logic [15:0] buf_q [64];
  logic [15:0] page_q [64];
  logic [63:0] ld_q;
  logic [8:0] erased_q, written_q;
  logic [5:0] lock_q;
  int n_dbl = 0;
  // Enable in bit 0, region busy in bit 6
  assign status_o = {1'h0, rww_q, 5'h00, en_q};
  ////////////////////////////////////////////////////////////////////////////////
  // Control register, store window and operation timer
  always @(posedge clk_i) begin
    if (rst_i) begin
      {en_q, rww_q, win_q, cnt_q, ld_q} <= '0;
      lock_q <= 6'h3F;
    end else begin
      if (ee_busy_i) ld_q <= '0;
      if (win_q != 3'h0) win_q <= win_q - 3'h1;
      if (ctrl_wr_i && !ee_busy_i && !en_q) begin
        ctl_q <= ctrl_i;
        en_q <= ctrl_i[0];
        win_q <= 3'h4;
      // Store in window latches the pointer
      end else if (store_i && en_q && win_q != 3'h0 && cnt_q == 10'h000) begin
        adr_q <= addr_i;
        win_q <= 3'h0;
        // One word per load, any order
        if (ctl_q[4:1] == 4'h0) begin
          if (ld_q[addr_i[6:1]]) n_dbl <= n_dbl + 1;
          buf_q[addr_i[6:1]] <= {dhi_i, dlo_i};
          ld_q[addr_i[6:1]] <= 1'b1;
          cnt_q <= 10'h002;
        end else if (ctl_q[4]) begin
          rww_q <= 1'b0;
          ld_q <= '0;
          cnt_q <= 10'h002;
        end else begin
          cnt_q <= op_cyc_i;
          rww_q <= |ctl_q[2:1];
          if (ctl_q[3]) lock_q <= lock_q & dlo_i[5:0];
        end
      end else if (en_q && cnt_q == 10'h000 && win_q == 3'h1) begin
        en_q <= 1'b0;
      end
      // Enable stands until the operation ends
      if (cnt_q != 10'h000) begin
        cnt_q <= cnt_q - 10'h001;
        if (cnt_q == 10'h001) begin
          en_q <= 1'b0;
          if (ctl_q[1]) erased_q <= adr_q[15:7];
          if (ctl_q[2]) begin
            written_q <= adr_q[15:7];
            page_q <= buf_q;
            ld_q <= '0;
          end
        end
      end
    end
  end
endmodule

/* File: fsps_host_tb.sv */
// Self-checking bench for the flash self-program host
module fsps_host_tb import fsps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, ee = 1'b0, pcw = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, s;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hrdy, hresp, cwr, sto;
  logic [7:0] ctl, dlo, dhi, dst, lctl, pctl, ldlo, v;
  logic [15:0] adr, ladr, padr;
  logic [15:0] ew [64];
  logic [9:0] opc = 10'h00A;
  logic [8:0] p;
  logic [5:0] ix;
  int n_mismatch = 0, tests_run = 0, n_cwr = 0, n_bad = 0, k, m;
  always #10 clk = ~clk;
  fsps_host #(.PROG_TIMEOUT_CYC(200)) uut (.CORE_CLK_I(clk), .SRST_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
    .DEV_CTRL_WR_O(cwr), .DEV_CTRL_O(ctl), .DEV_STORE_O(sto), .DEV_ADDR_O(adr),
    .DEV_DATA_LOW_O(dlo), .DEV_DATA_HIGH_O(dhi), .DEV_STATUS_I(dst), .DEV_EE_BUSY_I(ee));
  fsps_dev_model dev (.clk_i(clk), .rst_i(rst), .ctrl_wr_i(cwr), .ctrl_i(ctl), .store_i(sto),
    .addr_i(adr), .dlo_i(dlo), .dhi_i(dhi), .ee_busy_i(ee), .op_cyc_i(opc), .status_o(dst));
  // Strobe watch: store follows each control write by one cycle
  always @(posedge clk) begin
    if (!rst && sto !== pcw) n_bad++;
    pcw <= cwr;
    if (cwr === 1'b1) begin
      n_cwr++;
      pctl <= lctl;
      lctl <= ctl;
      padr <= ladr;
      ladr <= adr;
      ldlo <= dlo;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One edge with hready sampled high, bounded
  task tick;
    int n;
    n = 0;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        print_verdict;
      end
      @(posedge clk);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    tick;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    tick;
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  task done;
    int n;
    n = 0;
    s = 32'h0000_0001;
    while (s[ST_BUSY] !== 1'b0) begin
      rd(OFS_STATUS, s);
      n++;
      if (n > 3000) begin
        n_mismatch++;
        print_verdict;
      end
    end
  endtask
  task cmd(input logic [2:0] c);
    wr(OFS_CMD, {29'h0, c});
    done;
  endtask
  task refused(input string nm);
    rd(OFS_STATUS, s);
    chk(nm, 32'h0000_0002, s & 32'h0000_0002);
    wr(OFS_STATUS, 32'h0000_000E);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(24));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_STATUS, s);
    chk("status reset", 32'h0, s);
    wr(8'h10, $urandom());
    rd(8'h10, s);
    chk("unmapped", 32'h0, s);
    chk("hresp", 32'h0, 32'(hresp));
    $display("test reset done");
    opc <= 10'(20 + $urandom() % 100);
    p = 9'($urandom());
    wr(OFS_ADDR, {16'h0000, p, 7'h15});
    cmd(CMD_ERASE);
    chk("erase ctrl", 32'(CTRL_ERASE), 32'(pctl));
    chk("erase addr", 32'({p, 7'h00}), 32'(padr));
    chk("erase reen", 32'(CTRL_REEN), 32'(lctl));
    chk("erased page", 32'(p), 32'(dev.erased_q));
    chk("region busy", 32'h0, 32'(dev.rww_q));
    rd(OFS_STATUS, s);
    chk("erased flag", 32'h0000_0010, s & 32'h0000_0010);
    for (k = 0; k < 8; k++) begin
      ix = 6'(k * 23 + 5);
      ew[ix] = 16'($urandom());
      wr(OFS_ADDR, {16'h0000, p, ix, 1'b0});
      wr(OFS_DATA, {16'h0000, ew[ix]});
      cmd(CMD_LOAD);
      chk("load ctrl", 32'(CTRL_LOAD), 32'(lctl));
      chk("buffer word", 32'(ew[ix]), 32'(dev.buf_q[ix]));
    end
    wr(OFS_ADDR, {16'h0000, p, 6'h05, 1'b0});
    m = n_cwr;
    cmd(CMD_LOAD);
    refused("double load");
    chk("no double load", 32'(m), 32'(n_cwr));
    wr(OFS_ADDR, {16'h0000, p, 7'h2B});
    cmd(CMD_WRITE);
    chk("write ctrl", 32'(CTRL_WRITE), 32'(pctl));
    chk("write low bits", 32'h0, 32'(padr[6:0]));
    chk("write reen", 32'(CTRL_REEN), 32'(lctl));
    chk("written page", 32'(p), 32'(dev.written_q));
    chk("buffer empty", 32'h0, 32'(|dev.ld_q));
    for (k = 0; k < 8; k++) begin
      ix = 6'(k * 23 + 5);
      chk("page word", 32'(ew[ix]), 32'(dev.page_q[ix]));
    end
    m = n_cwr;
    cmd(CMD_WRITE);
    refused("write unerased");
    chk("no write", 32'(m), 32'(n_cwr));
    $display("test page done");
    v = 8'($urandom());
    wr(OFS_DATA, 32'(v));
    cmd(CMD_LOCK);
    chk("lock ctrl", 32'(CTRL_LOCK), 32'(lctl));
    chk("lock addr", 32'h0000_0001, 32'(dev.adr_q));
    chk("lock data", 32'(v | 8'hC0), 32'(ldlo));
    chk("lock bits", 32'(6'h3F & v[5:0]), 32'(dev.lock_q));
    chk("lock region", 32'h0, 32'(dev.rww_q));
    $display("test lock done");
    wr(OFS_ADDR, 32'h0000_0012);
    cmd(CMD_LOAD);
    ee <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFS_STATUS, s);
    chk("lost flag", 32'h0000_0024, s & 32'h0000_0024);
    chk("buffer lost", 32'h0, 32'(|dev.ld_q));
    m = n_cwr;
    wr(OFS_CMD, 32'(CMD_LOAD));
    repeat (20) @(posedge clk);
    chk("held by eeprom", 32'(m), 32'(n_cwr));
    wr(OFS_CMD, 32'(CMD_LOCK));
    refused("busy cmd");
    ee <= 1'b0;
    done;
    chk("after eeprom", 32'(m + 1), 32'(n_cwr));
    wr(OFS_STATUS, 32'h0000_000E);
    $display("test eeprom done");
    cmd(CMD_REEN);
    chk("reen ctrl", 32'(CTRL_REEN), 32'(lctl));
    chk("reen buffer", 32'h0, 32'(|dev.ld_q));
    m = n_cwr;
    cmd(CMD_LOAD);
    chk("load after reen", 32'(m + 1), 32'(n_cwr));
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_STATUS, s);
    chk("status mid reset", 32'h0, s);
    chk("reset buffer", 32'h0, 32'(|dev.ld_q));
    wr(OFS_ADDR, 32'h0000_0012);
    m = n_cwr;
    cmd(CMD_LOAD);
    chk("load after reset", 32'(m + 1), 32'(n_cwr));
    $display("test reuse done");
    opc <= 10'h12C;
    cmd(CMD_LOCK);
    rd(OFS_STATUS, s);
    chk("timeout flag", 32'h0000_0008, s & 32'h0000_0008);
    opc <= 10'h00A;
    repeat (400) @(posedge clk);
    wr(OFS_STATUS, 32'h0000_000E);
    for (k = 0; k < 8; k++) begin
      if (k == 0 || k > 5) begin
        wr(OFS_CMD, 32'(k));
        refused("bad code");
      end
    end
    chk("store spacing", 32'h0, 32'(n_bad));
    chk("model double load", 32'h0, 32'(dev.n_dbl));
    $display("test codes done");
    print_verdict;
  end
endmodule
